// file: design/lfs_pkg.sv
package lfs_pkg;
  // read addresses of the two status registers
  localparam logic [7:0] ADDR_STATUS0 = 8'h00;
  localparam logic [7:0] ADDR_STATUS1 = 8'h01;

  // fault_status_zero bit positions
  localparam int S0_DIS1 = 0;
  localparam int S0_DIS2 = 1;
  localparam int S0_OC1  = 2;
  localparam int S0_OC2  = 3;
  localparam int S0_PNG1 = 4;
  localparam int S0_PNG2 = 5;
  localparam int S0_UV   = 6;
  localparam int S0_TSD  = 7;

  // status register one bit positions
  localparam int S1_PUMP1  = 0;
  localparam int S1_PUMP2  = 1;
  localparam int S1_TONE1  = 2;
  localparam int S1_TONE2  = 3;
  localparam int S1_EPF    = 4;
  localparam int S1_TRIM   = 5;
  localparam int S1_BOOST1 = 6;
  localparam int S1_BOOST2 = 7;

  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [1:0] DIS_RESET    = 2'h3;

  // timing; clock is 20 MHz
  localparam int CLK_KHZ    = 20000;
  localparam int RETRY_MS   = 1000;
  localparam int EPF_D1_US  = 11500;
  localparam int EPF_D2_US  = 46000;
  localparam int EPF_D3_US  = 92000;
  localparam int TDIS_US    = 1000;
  localparam int CNT_W      = 25;
  localparam logic [CNT_W-1:0] CNT_ZERO = 25'h0000000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 25'h0000001;

  // fail delay select codes
  localparam logic [1:0] EPF_SEL_NONE = 2'h0;
  localparam logic [1:0] EPF_SEL_D1   = 2'h1;
  localparam logic [1:0] EPF_SEL_D2   = 2'h2;
  localparam logic [1:0] EPF_SEL_D3   = 2'h3;
endpackage

// file: design/lfs_hold_timer.sv
`timescale 1ns/1ps
// counts while run_i holds; done_o pulses when the count reaches limit_i,
// then the count restarts so a steady run gives a periodic pulse
module lfs_hold_timer (
  input  wire logic                      clk_sys_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      run_i,
  input  wire logic [lfs_pkg::CNT_W-1:0] limit_i,
  output wire logic                      done_o
);
  logic [lfs_pkg::CNT_W-1:0] cnt_r;
  logic [lfs_pkg::CNT_W-1:0] cnt_nxt;

  assign done_o  = run_i && (cnt_r == limit_i);
  assign cnt_nxt = (!run_i || done_o) ? lfs_pkg::CNT_ZERO : cnt_r + lfs_pkg::CNT_ONE;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt_r <= lfs_pkg::CNT_ZERO;
    else
      cnt_r <= cnt_nxt;
  end

  count_bound_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    run_i |-> cnt_r <= limit_i)
    else $error("hold timer ran past its limit");
endmodule

// file: design/lfs_fault_status.sv
`timescale 1ns/1ps
module lfs_fault_status #(
  parameter logic [lfs_pkg::CNT_W-1:0] TDIS_CYC   =
    lfs_pkg::CNT_W'(lfs_pkg::TDIS_US * lfs_pkg::CLK_KHZ / 1000),
  parameter logic [lfs_pkg::CNT_W-1:0] RETRY_CYC  =
    lfs_pkg::CNT_W'(lfs_pkg::RETRY_MS * lfs_pkg::CLK_KHZ),
  parameter logic [lfs_pkg::CNT_W-1:0] EPF_D1_CYC =
    lfs_pkg::CNT_W'(lfs_pkg::EPF_D1_US * lfs_pkg::CLK_KHZ / 1000),
  parameter logic [lfs_pkg::CNT_W-1:0] EPF_D2_CYC =
    lfs_pkg::CNT_W'(lfs_pkg::EPF_D2_US * lfs_pkg::CLK_KHZ / 1000),
  parameter logic [lfs_pkg::CNT_W-1:0] EPF_D3_CYC =
    lfs_pkg::CNT_W'(lfs_pkg::EPF_D3_US * lfs_pkg::CLK_KHZ / 1000)
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  // completed host read of one status register
  input  wire logic       read_done_i,
  input  wire logic [7:0] read_addr_i,
  output logic      [7:0] read_data_o,
  // control settings
  input  wire logic [1:0] channel_enable_i,
  input  wire logic [1:0] tone_control_i,
  input  wire logic       restart_mode_i,
  input  wire logic       fail_delay_bit0_i,
  input  wire logic       fail_delay_bit1_i,
  input  wire logic       trim_lock_i,
  // comparator levels
  input  wire logic       vin_low_i,
  input  wire logic       vreg_low_i,
  input  wire logic       vin_above_9v_i,
  input  wire logic [1:0] over_limit_i,
  input  wire logic       overtemp_i,
  input  wire logic [1:0] pump_voltage_low_i,
  input  wire logic [1:0] out_dev9_i,
  input  wire logic [1:0] out_within5_i,
  input  wire logic [1:0] tone_detect_tx_i,
  input  wire logic [1:0] tone_detect_rx_i,
  input  wire logic [1:0] boost_above_hi_i,
  input  wire logic [1:0] boost_below_lo_i,
  input  wire logic       fail_below_i,
  input  wire logic       fail_above_hys_i,
  // results
  output wire logic [1:0] channel_out_en_o,
  output wire logic       irq_n_o,
  output wire logic [7:0] fault_status_zero_o,
  output wire logic [7:0] fault_status_one_o
);
  logic       undervoltage_flag_r;
  logic       undervoltage_flag_nxt;
  logic [1:0] overcurrent_flag_r;
  logic [1:0] overcurrent_flag_nxt;
  logic       thermal_shutdown_flag_r;
  logic       thermal_shutdown_flag_nxt;
  logic       early_power_fail_r;
  logic       early_power_fail_nxt;
  logic       fail_ack_r;
  logic       fail_ack_nxt;
  logic [1:0] output_disabled_r;
  logic [1:0] output_disabled_nxt;
  logic [1:0] rearm_r;
  logic [1:0] rearm_nxt;
  logic [1:0] power_not_good_r;
  logic [1:0] power_not_good_nxt;
  logic [1:0] pump_ok_r;
  logic [1:0] tone_seen_r;
  logic [1:0] tone_seen_nxt;
  logic [1:0] boost_high_r;
  logic [1:0] boost_high_nxt;
  logic       irq_r;
  logic       irq_nxt;
  logic [7:0] read_data_nxt;

  logic                      read0;
  logic                      read1;
  logic                      uv_now;
  logic [1:0]                oc_trip;
  logic                      retry_tick;
  logic                      fail_delay_done;
  logic                      fail_delay_run;
  logic [1:0]                fail_delay_sel;
  logic [lfs_pkg::CNT_W-1:0] fail_delay_cyc;
  logic                      oc_clear_ok;
  logic                      tsd_clear_ok;
  logic [1:0]                chan_fault;
  logic                      irq_event;
  logic                      pending_nxt;

  assign read0 = read_done_i && (read_addr_i == lfs_pkg::ADDR_STATUS0);
  assign read1 = read_done_i && (read_addr_i == lfs_pkg::ADDR_STATUS1);

  // overcurrent qualification, one timer per channel
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_oc
    lfs_hold_timer u_oc_timer (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .run_i     (over_limit_i[ch]),
      .limit_i   (TDIS_CYC),
      .done_o    (oc_trip[ch])
    );
  end

  // free-running retry tick, only while auto-retry is chosen
  lfs_hold_timer u_retry_timer (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .run_i     (restart_mode_i),
    .limit_i   (RETRY_CYC),
    .done_o    (retry_tick)
  );

  // fail recovery delay
  assign fail_delay_sel = {fail_delay_bit1_i, fail_delay_bit0_i};
  assign fail_delay_cyc =
    (fail_delay_sel == lfs_pkg::EPF_SEL_D1) ? EPF_D1_CYC :
    (fail_delay_sel == lfs_pkg::EPF_SEL_D2) ? EPF_D2_CYC :
    (fail_delay_sel == lfs_pkg::EPF_SEL_D3) ? EPF_D3_CYC : lfs_pkg::CNT_ZERO;
  // delay restarts whenever the input sags again before it expires
  assign fail_delay_run = early_power_fail_r && fail_above_hys_i && !fail_below_i;

  lfs_hold_timer u_fail_timer (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .run_i     (fail_delay_run),
    .limit_i   (fail_delay_cyc),
    .done_o    (fail_delay_done)
  );

  // undervoltage: set wins over a same-cycle clearing read
  assign uv_now = vin_low_i || vreg_low_i;
  assign undervoltage_flag_nxt = uv_now ||
    (undervoltage_flag_r && !(read0 && vin_above_9v_i));

  // overcurrent and thermal: auto-retry tick or clearing read
  assign oc_clear_ok  = restart_mode_i ? retry_tick : read0;
  assign tsd_clear_ok = restart_mode_i ? retry_tick : read0;
  assign overcurrent_flag_nxt = oc_trip |
    (overcurrent_flag_r & ~({2{oc_clear_ok}} & ~over_limit_i));
  assign thermal_shutdown_flag_nxt = overtemp_i ||
    (thermal_shutdown_flag_r && !(tsd_clear_ok && !overtemp_i));

  // fail bit: needs the read and the elapsed delay
  assign fail_ack_nxt = early_power_fail_r && (fail_ack_r || read1) && !fail_below_i;
  assign early_power_fail_nxt = fail_below_i ||
    (early_power_fail_r && !(fail_delay_done && fail_ack_r));

  // output-disabled per channel
  assign chan_fault = {2{undervoltage_flag_r || thermal_shutdown_flag_r}}
                    | overcurrent_flag_r | pump_voltage_low_i;
  // latch mode wants the host to toggle enable; auto-retry re-enables itself
  assign rearm_nxt = output_disabled_r & (rearm_r | ~channel_enable_i);
  assign output_disabled_nxt = ~channel_enable_i | chan_fault |
    (output_disabled_r & ~({2{restart_mode_i}} | rearm_r));
  assign channel_out_en_o = ~output_disabled_r;

  // live bits
  assign power_not_good_nxt =
    (channel_enable_i & out_dev9_i) |
    (power_not_good_r & ~(channel_enable_i & out_within5_i & ~out_dev9_i));
  assign tone_seen_nxt = (tone_control_i & tone_detect_tx_i) |
                         (~tone_control_i & tone_detect_rx_i);
  assign boost_high_nxt = boost_above_hi_i |
                          (boost_high_r & ~boost_below_lo_i);

  // interrupt: only the four interrupting faults take part
  assign irq_event = (uv_now && !undervoltage_flag_r) ||
                     (|(oc_trip & ~overcurrent_flag_r)) ||
                     (overtemp_i && !thermal_shutdown_flag_r) ||
                     (fail_below_i && !early_power_fail_r);
  assign pending_nxt = undervoltage_flag_nxt || (|overcurrent_flag_nxt) ||
                       thermal_shutdown_flag_nxt || early_power_fail_nxt;
  assign irq_nxt = irq_event ||
                   (irq_r && !((read0 || read1) && !pending_nxt));
  assign irq_n_o = !(irq_r || undervoltage_flag_r);

  // register images
  assign fault_status_zero_o = {thermal_shutdown_flag_r, undervoltage_flag_r,
                                power_not_good_r, overcurrent_flag_r, output_disabled_r};
  assign fault_status_one_o  = {boost_high_r, trim_lock_i, early_power_fail_r,
                                tone_seen_r, pump_ok_r};
  // read data shows the image before the read's own clearing
  assign read_data_nxt = read0 ? fault_status_zero_o :
                         read1 ? fault_status_one_o  :
                         read_done_i ? lfs_pkg::STATUS_RESET : read_data_o;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      undervoltage_flag_r     <= 1'b0;
      overcurrent_flag_r      <= 2'h0;
      thermal_shutdown_flag_r <= 1'b0;
      early_power_fail_r      <= 1'b0;
      fail_ack_r              <= 1'b0;
      irq_r                   <= 1'b0;
    end
    else
    begin
      undervoltage_flag_r     <= undervoltage_flag_nxt;
      overcurrent_flag_r      <= overcurrent_flag_nxt;
      thermal_shutdown_flag_r <= thermal_shutdown_flag_nxt;
      early_power_fail_r      <= early_power_fail_nxt;
      fail_ack_r              <= fail_ack_nxt;
      irq_r                   <= irq_nxt;
    end
  end

  // channels come out of reset disabled until enabled
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      output_disabled_r <= lfs_pkg::DIS_RESET;
      rearm_r           <= 2'h0;
      power_not_good_r  <= 2'h0;
      pump_ok_r         <= 2'h0;
      tone_seen_r       <= 2'h0;
      boost_high_r      <= 2'h0;
      read_data_o       <= lfs_pkg::STATUS_RESET;
    end
    else
    begin
      output_disabled_r <= output_disabled_nxt;
      rearm_r           <= rearm_nxt;
      power_not_good_r  <= power_not_good_nxt;
      pump_ok_r         <= ~pump_voltage_low_i;
      tone_seen_r       <= tone_seen_nxt;
      boost_high_r      <= boost_high_nxt;
      read_data_o       <= read_data_nxt;
    end
  end

  uv_forces_off_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    undervoltage_flag_r |-> (!irq_n_o ##1 (output_disabled_r == 2'h3)))
    else $error("undervoltage did not force interrupt and disables");

  uv_clear_cause_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $fell(undervoltage_flag_r) |-> $past(read0 && vin_above_9v_i && !uv_now))
    else $error("undervoltage cleared without a qualifying read");

  dis_follows_en_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !channel_enable_i[0] |=> output_disabled_r[0] && !channel_out_en_o[0])
    else $error("channel one not disabled while enable is low");

  oc_qualify_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(overcurrent_flag_r[0]) |-> $past(over_limit_i[0]) ##1 output_disabled_r[0])
    else $error("overcurrent set without qualified current or disable");

  tone_select_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    tone_control_i[1] |=> tone_seen_r[1] == $past(tone_detect_tx_i[1]))
    else $error("transmit tone threshold not used");

  tsd_disables_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    overtemp_i |=> thermal_shutdown_flag_r ##1 (output_disabled_r == 2'h3))
    else $error("thermal shutdown did not disable both channels");

  fail_irq_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    fail_below_i |=> early_power_fail_r && !irq_n_o)
    else $error("fail input low did not set bit and interrupt");

  oc_latch_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !restart_mode_i && overcurrent_flag_r[1] && !read0 |=> overcurrent_flag_r[1])
    else $error("latched overcurrent cleared without a read");

  boost_track_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    boost_above_hi_i[0] ##1 (boost_below_lo_i[0] && !boost_above_hi_i[0])
      |=> !boost_high_r[0])
    else $error("boost-high did not follow its thresholds");

  irq_release_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(irq_n_o) |-> $past(read_done_i) || $past(undervoltage_flag_r))
    else $error("interrupt released without a status read");

  dis_clear_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $fell(output_disabled_r[0]) |-> $past(channel_enable_i[0] && !chan_fault[0]))
    else $error("channel one re-enabled with a fault or enable low");

  pump_low_off_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    pump_voltage_low_i[1] |=> !pump_ok_r[1] && output_disabled_r[1])
    else $error("low pump voltage did not clear pump-ok and disable");

  png_set_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    channel_enable_i[0] && out_dev9_i[0] |=> power_not_good_r[0])
    else $error("power-not-good not set on large deviation");

  png_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !channel_enable_i[1] |=> power_not_good_r[1] == $past(power_not_good_r[1]))
    else $error("power-not-good changed while channel disabled");

  tone_rx_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !tone_control_i[0] |=> tone_seen_r[0] == $past(tone_detect_rx_i[0]))
    else $error("receive tone threshold not used");

  boost_set_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    boost_above_hi_i[0] |=> boost_high_r[0])
    else $error("boost-high not set above upper threshold");

  live_no_irq_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $fell(irq_n_o) |-> $past(uv_now || (|oc_trip) || overtemp_i || fail_below_i))
    else $error("interrupt raised by a non-interrupting condition");

  fail_delay_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $fell(early_power_fail_r) |-> $past(fail_delay_done && fail_ack_r && !fail_below_i))
    else $error("fail bit cleared before read and delay");

  retry_clear_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    restart_mode_i && retry_tick && !overtemp_i |=> !thermal_shutdown_flag_r)
    else $error("retry tick did not clear thermal shutdown");

  oc_read_clear_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    read0 && !restart_mode_i && !over_limit_i[0] && !oc_trip[0] |=> !overcurrent_flag_r[0])
    else $error("read did not clear a removed overcurrent");

  read_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    read0 |=> read_data_o == $past(fault_status_zero_o))
    else $error("status zero read returned wrong image");

  read_one_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    read1 |=> read_data_o == $past(fault_status_one_o))
    else $error("status one read returned wrong image");

  irq_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    irq_r && pending_nxt |=> irq_r)
    else $error("interrupt released with a fault still pending");
endmodule

// file: verification/lfs_host_model.sv
`timescale 1ns/1ps
// far-side host: issues completed status reads, one byte each
module lfs_host_model (
  input  wire logic       clk_sys_i,
  output logic            read_done_o,
  output logic      [7:0] read_addr_o
);
  initial
  begin
    read_done_o = 1'b0;
    read_addr_o = 8'hFF;
  end
  // caller sits just after a falling edge; returns two cycles later
  task automatic rd(input logic [7:0] addr);
    read_done_o = 1'b1;
    read_addr_o = addr;
    @(negedge clk_sys_i);
    read_done_o = 1'b0;
    // stale address never matches the last one
    read_addr_o = ~addr;
    // idle cycle so back-to-back reads never retoggle the strobe in one step
    @(negedge clk_sys_i);
  endtask
endmodule

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic       clk_sys_i, rst_n_i, rd_done;
  logic [7:0] rd_addr, rdata, st0, st1;
  logic [1:0] en, tctl, ovl, pump_low, dev9, win5, tx, rx, b_hi, b_lo, out_en;
  logic       rmode, d0, d1, trim, vin_low, vreg_low, vin9, otemp, f_below, f_hys, irq_n;
  int         mismatches, checks_done, cycles;
  lfs_host_model u_lfs_host_model (.clk_sys_i(clk_sys_i), .read_done_o(rd_done),
    .read_addr_o(rd_addr));
  lfs_fault_status #(.TDIS_CYC(25'h0000008), .RETRY_CYC(25'h0000032),
    .EPF_D1_CYC(25'h0000005), .EPF_D2_CYC(25'h000000A), .EPF_D3_CYC(25'h0000014))
  u_lfs_fault_status (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .read_done_i(rd_done),
    .read_addr_i(rd_addr), .read_data_o(rdata), .channel_enable_i(en),
    .tone_control_i(tctl), .restart_mode_i(rmode), .fail_delay_bit0_i(d0),
    .fail_delay_bit1_i(d1), .trim_lock_i(trim), .vin_low_i(vin_low),
    .vreg_low_i(vreg_low), .vin_above_9v_i(vin9), .over_limit_i(ovl),
    .overtemp_i(otemp), .pump_voltage_low_i(pump_low), .out_dev9_i(dev9),
    .out_within5_i(win5), .tone_detect_tx_i(tx), .tone_detect_rx_i(rx),
    .boost_above_hi_i(b_hi), .boost_below_lo_i(b_lo), .fail_below_i(f_below),
    .fail_above_hys_i(f_hys), .channel_out_en_o(out_en), .irq_n_o(irq_n),
    .fault_status_zero_o(st0), .fault_status_one_o(st1));
  initial
  begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard: whole run needs well under a thousand cycles
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic t_reset();
    chk("st0 reset", 8'h03, st0);
    chk("read reset", 8'h00, rdata);
    chk("irq reset", 8'h01, {7'h00, irq_n});
    en = 2'b11;
    cyc(3);
    chk("st0 enabled", 8'h00, st0);
    chk("out_en on", 8'h03, {6'h00, out_en});
    en = 2'b01;
    cyc(3);
    chk("st0 ch2 off", 8'h02, st0);
    en = 2'b11;
    cyc(3);
    $display("test reset done");
  endtask
  task automatic t_uv();
    vin_low = 1'b1;
    cyc(3);
    chk("st0 uv", 8'h43, st0);
    chk("uv out_en", 8'h00, {6'h00, out_en});
    chk("uv irq", 8'h00, {7'h00, irq_n});
    vin_low = 1'b0;
    vin9 = 1'b0;
    u_lfs_host_model.rd(8'h00);
    chk("uv low vin read", 8'h43, st0);
    vin9 = 1'b1;
    u_lfs_host_model.rd(8'h00);
    chk("uv read data", 8'h43, rdata);
    chk("uv cleared", 8'h03, st0);
    chk("uv irq free", 8'h01, {7'h00, irq_n});
    en = 2'b00;
    cyc(2);
    en = 2'b11;
    cyc(3);
    chk("uv dis cleared", 8'h00, st0);
    $display("test undervoltage done");
  endtask
  task automatic t_oc();
    int n;
    n = 0;
    ovl = 2'b11;
    while (st0[2] !== 1'b1 && n < 20)
    begin
      cyc(1);
      n++;
    end
    chk("oc delay ok", 8'h01, {7'h00, n >= 9 && n <= 12});
    cyc(2);
    chk("oc st0", 8'h0F, st0);
    chk("oc irq", 8'h00, {7'h00, irq_n});
    u_lfs_host_model.rd(8'h00);
    chk("oc held", 8'h0F, st0);
    ovl = 2'b00;
    cyc(1);
    u_lfs_host_model.rd(8'h02);
    chk("oc unmapped read", 8'h0F, st0);
    chk("oc irq kept", 8'h00, {7'h00, irq_n});
    u_lfs_host_model.rd(8'h00);
    chk("oc cleared", 8'h03, st0);
    chk("oc irq free", 8'h01, {7'h00, irq_n});
    en = 2'b00;
    cyc(2);
    en = 2'b11;
    cyc(3);
    chk("oc dis cleared", 8'h00, st0);
    $display("test overcurrent done");
  endtask
  task automatic t_retry();
    int n;
    n = 0;
    rmode = 1'b1;
    otemp = 1'b1;
    ovl = 2'b10;
    cyc(3);
    chk("tsd st0", 8'h83, st0);
    otemp = 1'b0;
    cyc(1);
    u_lfs_host_model.rd(8'h00);
    chk("tsd kept on read", 8'h83, st0);
    cyc(4);
    chk("oc retry set", 8'h8B, st0);
    ovl = 2'b00;
    while (st0[7] !== 1'b0 && n < 60)
    begin
      cyc(1);
      n++;
    end
    chk("tsd tick", 8'h01, {7'h00, n <= 52});
    cyc(3);
    chk("tsd restarted", 8'h00, st0);
    chk("tsd irq held", 8'h00, {7'h00, irq_n});
    u_lfs_host_model.rd(8'h01);
    chk("tsd irq free", 8'h01, {7'h00, irq_n});
    rmode = 1'b0;
    $display("test auto retry done");
  endtask
  task automatic t_live();
    pump_low = 2'b10;
    trim = 1'b1;
    tctl = 2'b11;
    tx = 2'b11;
    b_hi = 2'b01;
    dev9 = 2'b01;
    win5 = 2'b00;
    cyc(3);
    chk("live st1", 8'h6D, st1);
    chk("live st0", 8'h12, st0);
    chk("live irq", 8'h01, {7'h00, irq_n});
    u_lfs_host_model.rd(8'h01);
    chk("read st1", 8'h6D, rdata);
    u_lfs_host_model.rd(8'h02);
    chk("read unmapped", 8'h00, rdata);
    tctl = 2'b00;
    rx = 2'b10;
    b_hi = 2'b00;
    dev9 = 2'b00;
    cyc(3);
    chk("live hold", 8'h69, st1);
    chk("png hold", 8'h12, st0);
    b_lo = 2'b11;
    win5 = 2'b11;
    pump_low = 2'b00;
    rx = 2'b00;
    cyc(3);
    chk("live clear", 8'h23, st1);
    chk("png clear", 8'h02, st0);
    en = 2'b01;
    cyc(2);
    en = 2'b11;
    trim = 1'b0;
    cyc(3);
    $display("test live bits done");
  endtask
  task automatic t_epf();
    int n;
    int dly[4];
    dly = '{0, 5, 10, 20};
    for (int c = 0; c < 4; c++)
    begin
      {d1, d0} = 2'(c);
      f_below = 1'b1;
      f_hys = 1'b0;
      cyc(2);
      chk("epf set", 8'h13, st1);
      chk("epf irq", 8'h00, {7'h00, irq_n});
      f_below = 1'b0;
      f_hys = 1'b1;
      u_lfs_host_model.rd(8'h01);
      chk("epf read", 8'h13, rdata);
      n = 0;
      while (st1[4] !== 1'b0 && n < 40)
      begin
        cyc(1);
        n++;
      end
      chk("epf delay", 8'h01, {7'h00, n + 2 >= dly[c] && n <= dly[c] + 3});
      u_lfs_host_model.rd(8'h00);
      chk("epf irq free", 8'h01, {7'h00, irq_n});
    end
    $display("test early fail done");
  endtask
  task automatic t_mid_reset();
    vreg_low = 1'b1;
    u_lfs_host_model.rd(8'h01);
    chk("uv from regulator", 8'h43, st0);
    chk("read before reset", 8'h03, rdata);
    rst_n_i = 1'b0;
    cyc(1);
    chk("st0 mid reset", 8'h03, st0);
    chk("read mid reset", 8'h00, rdata);
    chk("irq mid reset", 8'h01, {7'h00, irq_n});
    vreg_low = 1'b0;
    rst_n_i = 1'b1;
    cyc(2);
    chk("st0 after reset", 8'h03, st0);
    chk("irq after reset", 8'h01, {7'h00, irq_n});
    en = 2'b00;
    cyc(2);
    en = 2'b11;
    cyc(3);
    chk("st0 re-enabled", 8'h00, st0);
    $display("test mid-run reset done");
  endtask
  initial
  begin
    {rst_n_i, en, tctl, rmode, d0, d1, trim, vin_low, vreg_low} = '0;
    {ovl, otemp, pump_low, dev9, tx, rx, b_hi, b_lo, f_below} = '0;
    {vin9, f_hys, win5} = 4'hF;
    mismatches = 0;
    checks_done = 0;
    cycles = 0;
    cyc(5);
    rst_n_i = 1'b1;
    cyc(1);
    t_reset();
    t_uv();
    t_oc();
    t_retry();
    t_live();
    t_epf();
    t_mid_reset();
    wrap_up();
  end
endmodule
